// ===== core/fpc_ctrl.sv
/*
   host-side controller for a 256 x 4 fuse prom: single-word reads, one-link
   programming with timed pulses and a verify pass against an image that ends at the first miss.
   assumes external level shifters turn cs1_hv_en into 15 V on chip select 1
   and vprog_en[i] into 20 V on data pin i; dq_in comes from the prom pins.
*/
// Function
// R1 - prom holds 256 words of 4 bits, 8-bit address, each bit one-time
// R2 - both chip selects low drives stored word onto the outputs
// R3 - either chip select high turns outputs off, reads high or float
// R4 - intact link reads low, opened reads high; only low goes high
// R5 - open one link at a time; 20 V only after cs1 high
// R6 - raise cs1 to 15 V, after 50 us drop supply, enable, sense
// R7 - still intact: further 5 ms pulses, sensing after each
// R8 - intact after 400 ms total: stop, no more work on device; here dev_lock_ff blocks only further programming, reads and verify still run
// R9 - repeat the per-link procedure for each bit to set
// R10 - cap total programming at 5 s, then 5 s power off
// R11 - after programming, read all words and compare to the pattern; verify here stops at the first miss
`timescale 1ns/1ns
module fpc_ctrl (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   // command port
   input  wire logic                       rd_req,
   input  wire logic                       pgm_req,
   input  wire logic                       vfy_req,
   input  wire logic [fpc_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [fpc_pkg::DATA_W-1:0] cmd_bit,
   input  wire logic [fpc_pkg::DATA_W-1:0] img_data,
   output logic      [fpc_pkg::ADDR_W-1:0] img_addr,
   output logic                            busy,
   output logic                            done,
   output logic      [fpc_pkg::DATA_W-1:0] rd_data_ff,
   output logic                            fail_ff,
   output logic                            dev_lock_ff,
   output logic      [fpc_pkg::ADDR_W-1:0] miss_addr_ff,
   // prom pins
   output logic      [fpc_pkg::ADDR_W-1:0] prom_addr_ff,
   output logic                            cs1_n_ff,
   output logic                            cs2_n_ff,
   output logic                            cs1_hv_en_ff,
   output logic      [fpc_pkg::DATA_W-1:0] vprog_en_ff,
   output logic                            vcc_off_ff,
   input  wire logic [fpc_pkg::DATA_W-1:0] dq_in
);
   ////////////////////////////////////////////////////////////////////////
   fpc_pkg::fpc_state_e state_ff, nxt_state;
   logic [fpc_pkg::DATA_W-1:0] dq_m_ff, dq_s_ff;
   logic [fpc_pkg::CNT_W-1:0]  tmr_ff;
   logic [fpc_pkg::UNIT_W-1:0] link_units_ff, heat_units_ff, cool_units_ff;
   logic [fpc_pkg::DATA_W-1:0] bit_ff;
   logic                       first_ff;
   logic                       unit_tick;

   // open-collector parts read high and three-state parts float when deselected
   wire tmr_zero   = (tmr_ff == '0);
   wire sense_hit  = |(dq_s_ff & bit_ff);                              // [R4]
   wire one_hot    = (cmd_bit != '0) && ((cmd_bit & (cmd_bit - 1'b1)) == '0);
   wire link_over  = (link_units_ff >= fpc_pkg::UNIT_W'(fpc_pkg::LINK_UNITS));
   wire heat_over  = (heat_units_ff >= fpc_pkg::UNIT_W'(fpc_pkg::HEAT_UNITS));
   wire vfy_miss   = (dq_s_ff != img_data);                            // [R11]
   wire last_word  = (prom_addr_ff == fpc_pkg::ADDR_W'(fpc_pkg::WORDS - 1));
   // sized to the timer: an unsized wire would hold one bit of the length
   wire [fpc_pkg::CNT_W-1:0] pulse_len = first_ff ? fpc_pkg::CNT_W'(fpc_pkg::FIRST_CYC)
                                                  : fpc_pkg::CNT_W'(fpc_pkg::NEXT_CYC);
   // cooldown counts the same 50 us units as the heat budget
   wire cool_tick  = (state_ff == fpc_pkg::ST_COOL) && tmr_zero;             // [R10]

   assign busy     = (state_ff != fpc_pkg::ST_IDLE) && (state_ff != fpc_pkg::ST_DONE);
   assign done     = (state_ff == fpc_pkg::ST_DONE);
   assign img_addr = prom_addr_ff;
   // every first-pulse length of high voltage is one unit of budget
   assign unit_tick = (state_ff == fpc_pkg::ST_PPULSE)
                      && ((tmr_ff % fpc_pkg::CNT_W'(fpc_pkg::FIRST_CYC)) == '0);

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   always_ff @(posedge mclk) begin
      dq_m_ff <= dq_in;
      dq_s_ff <= dq_m_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         fpc_pkg::ST_IDLE: begin
            if (rd_req)
               nxt_state = fpc_pkg::ST_RDSET;
            else if (pgm_req && one_hot && !dev_lock_ff)
               nxt_state = heat_over ? fpc_pkg::ST_COOL : fpc_pkg::ST_PDESEL; // [R10]
            else if (vfy_req)
               nxt_state = fpc_pkg::ST_VFY;
         end
         fpc_pkg::ST_RDSET:  if (tmr_zero) nxt_state = fpc_pkg::ST_RDCAP;
         fpc_pkg::ST_RDCAP:  nxt_state = fpc_pkg::ST_DONE;
         fpc_pkg::ST_PDESEL: if (tmr_zero) nxt_state = fpc_pkg::ST_PVOUT;   // [R5]
         fpc_pkg::ST_PVOUT:  if (tmr_zero) nxt_state = fpc_pkg::ST_PPULSE;  // [R6]
         fpc_pkg::ST_PPULSE: if (tmr_zero) nxt_state = fpc_pkg::ST_PDROP;   // [R6]
         fpc_pkg::ST_PDROP:  if (tmr_zero) nxt_state = fpc_pkg::ST_PSENSE;
         fpc_pkg::ST_PSENSE: begin
            if (tmr_zero) begin
               if (sense_hit || link_over)                              // [R8]
                  nxt_state = fpc_pkg::ST_DONE;
               else if (heat_over)
                  nxt_state = fpc_pkg::ST_COOL;                          // [R10]
               else
                  nxt_state = fpc_pkg::ST_PDESEL;                        // [R7]
            end
         end
         fpc_pkg::ST_COOL: begin
            if (cool_units_ff >= fpc_pkg::UNIT_W'(fpc_pkg::COOL_UNITS))
               nxt_state = fpc_pkg::ST_PDESEL;                           // [R10]
         end
         fpc_pkg::ST_VFY:   if (tmr_zero) nxt_state = fpc_pkg::ST_VCAP;
         fpc_pkg::ST_VCAP: begin
            if (vfy_miss || last_word)
               nxt_state = fpc_pkg::ST_DONE;
            else
               nxt_state = fpc_pkg::ST_VFY;                              // [R11]
         end
         fpc_pkg::ST_DONE:  nxt_state = fpc_pkg::ST_IDLE;
         default:           nxt_state = fpc_pkg::ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!resetn)
         state_ff <= fpc_pkg::ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // timer loads on every state change; settle covers read access as well
   always_ff @(posedge mclk) begin
      if (!resetn)
         tmr_ff <= '0;
      else if (nxt_state != state_ff || state_ff == fpc_pkg::ST_VCAP || cool_tick) begin
         case (nxt_state)
            fpc_pkg::ST_PPULSE: tmr_ff <= pulse_len - 1'b1;             // [R6] [R7]
            fpc_pkg::ST_COOL:   tmr_ff <= fpc_pkg::CNT_W'(fpc_pkg::FIRST_CYC - 1); // [R10]
            default:            tmr_ff <= fpc_pkg::CNT_W'(fpc_pkg::SETTLE_CYC + 2);
         endcase
      end else if (!tmr_zero)
         tmr_ff <= tmr_ff - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive: cs2 stays low, cs1 carries select and the 15 V gate
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cs1_n_ff     <= 1'b1;
         cs2_n_ff     <= 1'b1;
         cs1_hv_en_ff <= 1'b0;
         vprog_en_ff  <= '0;
         vcc_off_ff   <= 1'b0;
      end else begin
         cs2_n_ff     <= 1'b0;
         cs1_n_ff     <= !(nxt_state inside {fpc_pkg::ST_RDSET, fpc_pkg::ST_RDCAP,
                                             fpc_pkg::ST_PSENSE, fpc_pkg::ST_VFY,
                                             fpc_pkg::ST_VCAP});              // [R2] [R3]
         // 20 V only to the single chosen output, after cs1 is already high
         vprog_en_ff  <= (nxt_state inside {fpc_pkg::ST_PVOUT, fpc_pkg::ST_PPULSE})
                         ? bit_ff : '0;                                       // [R5]
         cs1_hv_en_ff <= (nxt_state == fpc_pkg::ST_PPULSE);                   // [R6]
         vcc_off_ff   <= (nxt_state == fpc_pkg::ST_COOL);                     // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         prom_addr_ff  <= '0;
         bit_ff        <= '0;
         first_ff      <= 1'b1;
         link_units_ff <= '0;
         heat_units_ff <= '0;
         cool_units_ff <= '0;
         rd_data_ff    <= '0;
         fail_ff       <= 1'b0;
         dev_lock_ff   <= 1'b0;
         miss_addr_ff  <= '0;
      end else begin
         if (state_ff == fpc_pkg::ST_IDLE && nxt_state != fpc_pkg::ST_IDLE) begin
            prom_addr_ff  <= (nxt_state == fpc_pkg::ST_VFY) ? '0 : cmd_addr; // [R1] [R9]
            bit_ff        <= cmd_bit;
            first_ff      <= 1'b1;
            link_units_ff <= '0;
            fail_ff       <= 1'b0;
         end
         if (unit_tick) begin
            link_units_ff <= link_units_ff + 1'b1;                   // [R8]
            heat_units_ff <= heat_units_ff + 1'b1;                   // [R10]
         end
         if (state_ff == fpc_pkg::ST_PSENSE && tmr_zero) begin
            first_ff <= 1'b0;                                        // [R7]
            if (!sense_hit && link_over) begin
               fail_ff     <= 1'b1;
               dev_lock_ff <= 1'b1;                                  // [R8]
            end
         end
         if (state_ff == fpc_pkg::ST_COOL) begin
            if (tmr_zero && cool_units_ff < fpc_pkg::UNIT_W'(fpc_pkg::COOL_UNITS)) begin
               cool_units_ff <= cool_units_ff + 1'b1;
            end
            if (nxt_state != fpc_pkg::ST_COOL) begin
               heat_units_ff <= '0;                                  // [R10]
               cool_units_ff <= '0;
            end
         end
         if (state_ff == fpc_pkg::ST_RDCAP)
            rd_data_ff <= dq_s_ff;
         if (state_ff == fpc_pkg::ST_VCAP) begin
            rd_data_ff <= dq_s_ff;
            if (vfy_miss) begin
               fail_ff      <= 1'b1;                                 // [R11]
               miss_addr_ff <= prom_addr_ff;
            end else if (!last_word)
               prom_addr_ff <= prom_addr_ff + 1'b1;
         end
      end
   end
endmodule : fpc_ctrl

// ===== core/fpc_pkg.sv
/*
   constants for the fuse prom programmer / reader controller.
   assumes a 50 MHz mclk; analog switching of the 15 V and 20 V rails is done
   by external drivers steered by the enables this block produces.
*/
package fpc_pkg;
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 4;
   localparam int unsigned WORDS          = 256;
   // programming times, as printed
   localparam int unsigned FIRST_PULSE_US = 50;
   localparam int unsigned NEXT_PULSE_MS  = 5;
   localparam int unsigned LINK_LIMIT_MS  = 400;
   localparam int unsigned HEAT_LIMIT_S   = 5;
   localparam int unsigned COOL_S         = 5;
   // edge-to-edge settle, at least 100 ns
   localparam int unsigned SETTLE_NS      = 100;
   // derived cycle counts
   localparam int unsigned FIRST_CYC  = FIRST_PULSE_US * CLK_MHZ;
   localparam int unsigned NEXT_CYC   = NEXT_PULSE_MS * 1000 * CLK_MHZ;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   // budgets counted in first-pulse units (50 us each)
   localparam int unsigned NEXT_UNITS  = NEXT_CYC / FIRST_CYC;
   localparam int unsigned LINK_UNITS  = LINK_LIMIT_MS * 1000 / FIRST_PULSE_US;
   localparam int unsigned HEAT_UNITS  = HEAT_LIMIT_S * 1000000 / FIRST_PULSE_US;
   localparam int unsigned COOL_UNITS  = COOL_S * 1000000 / FIRST_PULSE_US;
   localparam int unsigned CNT_W       = 24;
   localparam int unsigned UNIT_W      = 20;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_RDSET  = 4'h1,
      ST_RDCAP  = 4'h2,
      ST_PDESEL = 4'h3,
      ST_PVOUT  = 4'h4,
      ST_PPULSE = 4'h5,
      ST_PDROP  = 4'h6,
      ST_PSENSE = 4'h7,
      ST_COOL   = 4'h8,
      ST_VFY    = 4'h9,
      ST_VCAP   = 4'hA,
      ST_DONE   = 4'hB
   } fpc_state_e;
endpackage : fpc_pkg

// ===== testbench/fpc_ctrl_assertions.sv
/* pin-protocol checker for the fuse prom controller.
   assumes it is bound to fpc_ctrl and sees only its ports. */
`timescale 1ns/1ns
module fpc_ctrl_assertions (
   // clock and reset
   input wire logic                       mclk,
   input wire logic                       resetn,
   // command port
   input wire logic                       rd_req,
   input wire logic                       pgm_req,
   input wire logic                       vfy_req,
   input wire logic [fpc_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [fpc_pkg::DATA_W-1:0] cmd_bit,
   input wire logic                       busy,
   input wire logic                       done,
   // prom pins
   input wire logic [fpc_pkg::ADDR_W-1:0] prom_addr_ff,
   input wire logic                       cs1_n_ff,
   input wire logic                       cs2_n_ff,
   input wire logic                       cs1_hv_en_ff,
   input wire logic [fpc_pkg::DATA_W-1:0] vprog_en_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // length of the current 15 V pulse, cleared as soon as it ends
   logic [fpc_pkg::CNT_W-1:0] hv_cnt_ff;
   always_ff @(posedge mclk) begin
      if (!resetn || !cs1_hv_en_ff) hv_cnt_ff <= '0;
      else hv_cnt_ff <= hv_cnt_ff + 1'b1;
   end
   ////////////////////////////////////////////////////////////
   sequence s_supply_off; vprog_en_ff == 4'h0 && cs1_n_ff; endsequence
   sequence s_sense; !cs1_n_ff; endsequence
   property p_hv_desel; cs1_hv_en_ff |-> cs1_n_ff; endproperty
   property p_one_link; cs1_hv_en_ff |-> $onehot(vprog_en_ff); endproperty
   property p_vprog_late; $rose(|vprog_en_ff) |-> cs1_n_ff && $past(cs1_n_ff); endproperty
   property p_hv_after; $rose(cs1_hv_en_ff) |-> $past(vprog_en_ff) != 4'h0; endproperty
   property p_pulse_len; $fell(cs1_hv_en_ff) |-> hv_cnt_ff >= fpc_pkg::FIRST_CYC; endproperty
   property p_drop_sense; $fell(cs1_hv_en_ff) |-> ##[0:8] s_supply_off ##[1:16] s_sense;
   endproperty
   property p_read_take; !busy && !done && rd_req |=> busy && !cs1_n_ff && !cs2_n_ff
      && prom_addr_ff == $past(cmd_addr); endproperty
   property p_refuse; !busy && !done && pgm_req && !rd_req && !vfy_req
      && !$onehot(cmd_bit) |=> !busy; endproperty
   a_hv_desel: assert property (p_hv_desel) else $error("15 V while selected");
   a_one_link: assert property (p_one_link) else $error("not one output");
   a_vprog_late: assert property (p_vprog_late) else $error("20 V too early");
   a_hv_after: assert property (p_hv_after) else $error("15 V before 20 V");
   a_pulse_len: assert property (p_pulse_len) else $error("pulse too short");
   a_drop_sense: assert property (p_drop_sense) else $error("no drop then sense");
   a_read_take: assert property (p_read_take) else $error("read not started");
   a_refuse: assert property (p_refuse) else $error("two-bit program taken");
endmodule : fpc_ctrl_assertions
bind fpc_ctrl fpc_ctrl_assertions chk_i (.mclk, .resetn, .rd_req, .pgm_req, .vfy_req,
   .cmd_addr, .cmd_bit, .busy, .done, .prom_addr_ff, .cs1_n_ff, .cs2_n_ff, .cs1_hv_en_ff,
   .vprog_en_ff);

// ===== testbench/fpc_prom_model.sv
/* behavioural 256 x 4 fuse prom, open-collector flavour.
   assumes the controller's pin registers drive it on mclk. */
`timescale 1ns/1ns
module fpc_prom_model #(
   parameter int BLOW_CYC = fpc_pkg::FIRST_CYC / 2
) (
   // pins
   input  wire logic                       mclk,
   input  wire logic [fpc_pkg::ADDR_W-1:0] addr,
   input  wire logic                       cs1_n,
   input  wire logic                       cs2_n,
   input  wire logic                       hv,
   input  wire logic [fpc_pkg::DATA_W-1:0] vprog,
   output logic      [fpc_pkg::DATA_W-1:0] dq
);
   logic [fpc_pkg::DATA_W-1:0] mem [fpc_pkg::WORDS];
   int                         hot;
   ////////////////////////////////////////////////////////////
   initial begin
      hot = 0;
      foreach (mem[i]) mem[i] = 4'h0; // fresh part, links intact
   end
   // deselected outputs float to the pull-up, so they read high
   assign dq = (cs1_n || cs2_n) ? 4'hF : mem[addr];
   // only one supplied output under 15 V heats a link
   always @(posedge mclk) begin
      hot = (hv && cs1_n && $onehot(vprog)) ? hot + 1 : 0;
      if (hot == BLOW_CYC) mem[addr] <= mem[addr] | vprog; // low to high only
   end
endmodule : fpc_prom_model

// ===== testbench/fuse_prom_read_and_program_test.sv
/* self-checking bench: reads, single-link programming, verify pass.
   assumes fpc_prom_model on the pins; retries and cooldown are too long to run. */
`timescale 1ns/1ns
module fuse_prom_read_and_program_test;
   localparam int LIMIT = 3 * fpc_pkg::FIRST_CYC;
   logic                       mclk, resetn, rd_req, pgm_req, vfy_req, busy, done;
   logic                       fail_ff, dev_lock_ff, cs1_n_ff, cs2_n_ff, cs1_hv_en_ff;
   logic                       vcc_off_ff;
   logic [fpc_pkg::ADDR_W-1:0] cmd_addr, img_addr, miss_addr_ff, prom_addr_ff;
   logic [fpc_pkg::DATA_W-1:0] cmd_bit, rd_data_ff, vprog_en_ff, dq_in;
   logic [fpc_pkg::DATA_W-1:0] img [fpc_pkg::WORDS];
   int                         mismatches, compares;
   fpc_ctrl dut (.mclk, .resetn, .rd_req, .pgm_req, .vfy_req, .cmd_addr, .cmd_bit,
      .img_data(img[img_addr]), .img_addr, .busy, .done, .rd_data_ff, .fail_ff,
      .dev_lock_ff, .miss_addr_ff, .prom_addr_ff, .cs1_n_ff, .cs2_n_ff, .cs1_hv_en_ff,
      .vprog_en_ff, .vcc_off_ff, .dq_in);
   fpc_prom_model prom (.mclk, .addr(prom_addr_ff), .cs1_n(cs1_n_ff), .cs2_n(cs2_n_ff),
      .hv(cs1_hv_en_ff), .vprog(vprog_en_ff), .dq(dq_in));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one request pulse, then a bounded wait for done
   task automatic op(input logic [1:0] kind, input logic [7:0] a, input logic [3:0] b);
      int n;
      @(negedge mclk);
      cmd_addr = a;
      cmd_bit = b;
      rd_req = (kind == 2'h0);
      pgm_req = (kind == 2'h1);
      vfy_req = (kind == 2'h2);
      @(negedge mclk);
      {rd_req, pgm_req, vfy_req} = 3'h0;
      for (n = 0; n < LIMIT && done !== 1'b1; n++) @(negedge mclk);
      chk("done", 8'h01, {7'h00, done});
   endtask : op
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////
   task automatic t_read_blank();
      op(2'h0, 8'hFF, 4'h0);
      chk("blank word", 8'h00, {4'h0, rd_data_ff});
   endtask : t_read_blank
   task automatic t_prog(input logic [7:0] a, input logic [3:0] b);
      op(2'h1, a, b);
      img[a] = img[a] | b;
      chk("program fail", 8'h00, {7'h00, fail_ff});
      chk("device lock", 8'h00, {7'h00, dev_lock_ff});
      chk("power off", 8'h00, {7'h00, vcc_off_ff});
      op(2'h0, a, 4'h0);
      chk("read back", {4'h0, img[a]}, {4'h0, rd_data_ff});
   endtask : t_prog
   task automatic t_refuse();
      @(negedge mclk);
      cmd_addr = 8'h20;
      cmd_bit = 4'h3;
      pgm_req = 1'b1;
      repeat (2) @(negedge mclk);
      chk("busy on two bits", 8'h00, {7'h00, busy});
      pgm_req = 1'b0;
   endtask : t_refuse
   task automatic t_verify(input logic bad);
      if (bad) img[8'h80] = 4'h2;
      op(2'h2, 8'h00, 4'h0);
      chk("verify fail", {7'h00, bad}, {7'h00, fail_ff});
      if (bad) chk("miss address", 8'h80, miss_addr_ff);
      img[8'h80] = 4'h0;
   endtask : t_verify
   ////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // a hang ends the run the same way as the tests
   initial begin
      repeat (8 * LIMIT) @(posedge mclk);
      mismatches++;
      wrap_up();
   end
   initial begin
      {resetn, rd_req, pgm_req, vfy_req} = 4'h0;
      cmd_addr = 8'h00;
      cmd_bit = 4'h0;
      mismatches = 0;
      compares = 0;
      foreach (img[i]) img[i] = 4'h0;
      repeat (2) @(negedge mclk);
      resetn = 1'b1;
      t_read_blank();
      t_prog(8'h00, 4'h1);
      t_prog(8'hFF, 4'h8);
      t_prog(8'h00, 4'h4);
      t_refuse();
      t_verify(1'b0);
      t_verify(1'b1);
      wrap_up();
   end
endmodule : fuse_prom_read_and_program_test
